/* core/cws_carrier_watchdog.sv */
// Purpose: Carrier output, watchdog and stop-mode control with APB access
// Assumes: Oscillator clock is mclk_i; wake inputs synchronous
// Notes:   Options are build-time parameters
//
// Overview of operation
// - Y value selects the carrier mode
// - Modes 0,1,6: period 12, high 1/2,1/3,1/4
// - Modes 2,3: period 8, high 1/2,1/4
// - Mode 4: period 11, high 4 clocks
// - Mode 5 generates no pulses
// - Slow cycle option: periods eight times longer
// - Option picks 48 or 6 clock cycle
// - Watchdog: 14 stages, fed at osc/6
// - Watchdog overflow causes internal reset
// - Clear instruction clears the watchdog
// - Option: carrier start also clears watchdog
// - Watchdog held clear in stop mode
// - Stop instruction halts the oscillator
// - Stop drives upper pair and carrier low
// - Other state kept during stop
// - Option: lower lines low or kept in stop
// - Enabled inputs low end stop mode
// - Wake restores lower lines and carrier
// - Wait 1024 times 8 clocks after wake
// - Stop with wake input low acts idle
// - Set starts carrier, reset stops it

`timescale 1ns/10ps

module cws_carrier_watchdog #(
	parameter bit OPT_SLOW_CYCLE  = 1'b0,
	parameter bit OPT_WDT_BY_CAR  = 1'b0,
	parameter bit OPT_STOP_LOWER0 = 1'b0,
	parameter int WDT_OVF_TICKS   = cws_pkg::WDT_OVF_TICKS,
	parameter int WAKE_WAIT_CYC   = cws_pkg::WAKE_WAIT_CYC
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic [3:0]  wake_k_i,
	input  wire logic [3:0]  wake_r_i,
	output logic      [7:0]  lower_output_lines_o,
	output logic      [1:0]  upper_output_pair_o,
	output logic             carrier_output_pin_o,
	output logic             wdt_reset_o,
	output logic             stop_mode_o,
	output logic             osc_run_o
);

	// ----------------------------------------
	// Local constants
	// ----------------------------------------
	localparam int CYC_LEN = OPT_SLOW_CYCLE ? cws_pkg::CYC_SLOW : cws_pkg::CYC_FAST;
	localparam logic [5:0]  CYC_LAST  = 6'(CYC_LEN - 1);
	localparam logic [13:0] WAIT_LAST = 14'(WAKE_WAIT_CYC - 1);

	// ----------------------------------------
	// State
	// ----------------------------------------
	cws_pkg::cws_state_type state_reg, state_next;
	logic [5:0]  cyc_reg, cyc_next;
	logic [13:0] wait_reg, wait_next;
	logic [3:0]  y_reg, y_next, op_reg, op_next;
	logic [1:0]  x_reg, x_next, upper_reg, upper_next, upper_pin_reg, upper_pin_next;
	logic [7:0]  wake_en_reg, wake_en_next, lower_reg, lower_next, lower_pin_reg, lower_pin_next;
	logic [2:0]  mode_reg, mode_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        car_on_reg, car_on_next, pend_reg, pend_next, pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next, car_pin_reg, car_pin_next, wdt_rst_reg, wdt_rst_next;
	logic        stop_pin_reg, stop_pin_next, osc_pin_reg, osc_pin_next;

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	logic        wdt_clr, wdt_ovf, car_run, car_restart, car_level;
	logic        exec, wake_hit, apb_acc, addr_ok;
	logic [13:0] wdt_count;
	logic [6:0]  car_period, car_high;

	cws_wdt_cnt #(
		.OVF_TICKS (WDT_OVF_TICKS)
	) u_wdt (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.ce_i    (ce_i),
		.clr_i   (wdt_clr),
		.count_o (wdt_count),
		.ovf_o   (wdt_ovf)
	);

	cws_carrier_gen u_car (
		.mclk_i    (mclk_i),
		.rst_b_i   (rst_b_i),
		.ce_i      (ce_i),
		.run_i     (car_run),
		.restart_i (car_restart),
		.period_i  (car_period),
		.high_i    (car_high),
		.level_o   (car_level)
	);

	// ----------------------------------------
	// Carrier mode table
	// ----------------------------------------
	always_comb begin
		case (mode_reg)
			3'h1: begin
				car_period = cws_pkg::PER_12;
				car_high   = cws_pkg::HI_4;
			end
			3'h2: begin
				car_period = cws_pkg::PER_8;
				car_high   = cws_pkg::HI_4;
			end
			3'h3: begin
				car_period = cws_pkg::PER_8;
				car_high   = cws_pkg::HI_2;
			end
			3'h4: begin
				car_period = cws_pkg::PER_11;
				car_high   = cws_pkg::HI_4;
			end
			3'h6: begin
				car_period = cws_pkg::PER_12;
				car_high   = cws_pkg::HI_3;
			end
			default: begin
				car_period = cws_pkg::PER_12;
				car_high   = cws_pkg::HI_6;
			end
		endcase
		if (OPT_SLOW_CYCLE) begin
			car_period = car_period << cws_pkg::SLOW_SHIFT;
			car_high   = car_high << cws_pkg::SLOW_SHIFT;
		end
	end

	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	assign exec     = pend_reg && (cyc_reg == CYC_LAST) && (state_reg == cws_pkg::ST_RUN);
	assign wake_hit = |(wake_en_reg & ~{wake_r_i, wake_k_i});
	assign apb_acc  = psel_i && penable_i && !pready_reg;
	assign addr_ok  = (paddr_i == cws_pkg::ADDR_CMD) || (paddr_i == cws_pkg::ADDR_XY) ||
		(paddr_i == cws_pkg::ADDR_WAKE) || (paddr_i == cws_pkg::ADDR_STAT) ||
		(paddr_i == cws_pkg::ADDR_OUT);

	assign car_restart = exec && (op_reg == cws_pkg::OP_SO) && (y_reg == cws_pkg::Y_CARRIER);
	assign car_run     = car_on_reg && (mode_reg != cws_pkg::MODE_STATIC) &&
		(state_reg != cws_pkg::ST_STOP);

	assign wdt_clr = (state_reg == cws_pkg::ST_STOP) ||
		(exec && op_reg == cws_pkg::OP_WATCHDOG_CLEAR_INSTRUCTION) ||
		(OPT_WDT_BY_CAR && car_restart);

	// ----------------------------------------
	// Instruction execution and stop control
	// ----------------------------------------
	always_comb begin
		state_next   = state_reg;
		cyc_next     = (cyc_reg == CYC_LAST) ? 6'h00 : cyc_reg + 6'h01;
		wait_next    = wait_reg;
		y_next       = y_reg;
		x_next       = x_reg;
		wake_en_next = wake_en_reg;
		mode_next    = mode_reg;
		car_on_next  = car_on_reg;
		lower_next   = lower_reg;
		upper_next   = upper_reg;
		pend_next    = pend_reg;
		op_next      = op_reg;
		wdt_rst_next = 1'b0;
		if (exec) begin
			pend_next = 1'b0;
			case (op_reg)
				cws_pkg::OP_SO, cws_pkg::OP_RO: begin
					if (x_reg[1]) begin
						if (y_reg[3:1] == 3'h0) begin
							upper_next[y_reg[0]] = (op_reg == cws_pkg::OP_SO);
						end
					end else if (!y_reg[3]) begin
						lower_next[y_reg[2:0]] = (op_reg == cws_pkg::OP_SO);
					end else if (y_reg == cws_pkg::Y_CARRIER) begin
						car_on_next = (op_reg == cws_pkg::OP_SO);
					end else if (y_reg == cws_pkg::Y_ALL) begin
						lower_next = {8{op_reg == cws_pkg::OP_SO}};
						upper_next = {2{op_reg == cws_pkg::OP_SO}};
					end
				end
				cws_pkg::OP_LPY: begin
					mode_next = y_reg[2:0];
				end
				cws_pkg::OP_STOP: begin
					if (!wake_hit) begin
						state_next = cws_pkg::ST_STOP;
						upper_next = 2'h0;
					end
				end
				default: pend_next = 1'b0;
			endcase
		end
		case (state_reg)
			cws_pkg::ST_STOP: begin
				cyc_next = cyc_reg;
				if (wake_hit) begin
					state_next = cws_pkg::ST_WAIT;
					wait_next  = 14'h0000;
				end
			end
			cws_pkg::ST_WAIT: begin
				cyc_next  = 6'h00;
				wait_next = wait_reg + 14'h0001;
				if (wait_reg == WAIT_LAST) begin
					state_next = cws_pkg::ST_RUN;
				end
			end
			default: wait_next = wait_reg;
		endcase
		if (apb_acc && pwrite_i) begin
			if (paddr_i == cws_pkg::ADDR_XY) begin
				y_next = pwdata_i[cws_pkg::Y_LSB +: 4];
				x_next = pwdata_i[cws_pkg::X_LSB +: 2];
			end
			if (paddr_i == cws_pkg::ADDR_WAKE) begin
				wake_en_next = pwdata_i[7:0];
			end
			if (paddr_i == cws_pkg::ADDR_CMD && !pend_reg && state_reg == cws_pkg::ST_RUN) begin
				pend_next = (pwdata_i[3:0] != cws_pkg::OP_IDLE);
				op_next   = pwdata_i[3:0];
			end
		end
		if (wdt_ovf) begin
			state_next   = cws_pkg::ST_RUN;
			cyc_next     = 6'h00;
			y_next       = 4'h0;
			x_next       = 2'h0;
			mode_next    = cws_pkg::MODE_RESET;
			car_on_next  = 1'b0;
			lower_next   = 8'h00;
			upper_next   = 2'h0;
			pend_next    = 1'b0;
			wdt_rst_next = 1'b1;
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	always_comb begin
		lower_pin_next = lower_reg;
		upper_pin_next = upper_reg;
		stop_pin_next  = (state_next == cws_pkg::ST_STOP);
		osc_pin_next   = (state_next != cws_pkg::ST_STOP);
		car_pin_next   = car_on_reg && (car_run ? car_level : 1'b1);
		if (state_reg == cws_pkg::ST_STOP) begin
			upper_pin_next = 2'h0;
			car_pin_next   = 1'b0;
			if (OPT_STOP_LOWER0) begin
				lower_pin_next = 8'h00;
			end
		end
	end

	// ----------------------------------------
	// APB slave: one wait state, then answer
	// ----------------------------------------
	always_comb begin
		pready_next  = apb_acc;
		pslverr_next = apb_acc && !addr_ok;
		prdata_next  = 32'h0000_0000;
		if (apb_acc && !pwrite_i) begin
			case (paddr_i)
				cws_pkg::ADDR_CMD: prdata_next[4:0] = {pend_reg, op_reg};
				cws_pkg::ADDR_XY: prdata_next[5:0] = {x_reg, y_reg};
				cws_pkg::ADDR_WAKE: prdata_next[7:0] = wake_en_reg;
				cws_pkg::ADDR_STAT: begin
					prdata_next[1:0] = state_reg;
					prdata_next[cws_pkg::STAT_WDT +: 14] = wdt_count;
				end
				cws_pkg::ADDR_OUT: begin
					prdata_next[7:0] = lower_pin_reg;
					prdata_next[cws_pkg::OUT_UPPER +: 2] = upper_pin_reg;
					prdata_next[cws_pkg::OUT_CAR]   = car_pin_reg;
					prdata_next[cws_pkg::OUT_CARON] = car_on_reg;
					prdata_next[cws_pkg::OUT_MODE +: 3] = mode_reg;
				end
				default: prdata_next = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Registers; external reset timing is the board's duty
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg     <= cws_pkg::ST_RUN;
			cyc_reg       <= 6'h00;
			wait_reg      <= 14'h0000;
			y_reg         <= 4'h0;
			x_reg         <= 2'h0;
			wake_en_reg   <= 8'h00;
			mode_reg      <= cws_pkg::MODE_RESET;
			car_on_reg    <= 1'b0;
			lower_reg     <= 8'h00;
			upper_reg     <= 2'h0;
			pend_reg      <= 1'b0;
			op_reg        <= cws_pkg::OP_IDLE;
			prdata_reg    <= 32'h0000_0000;
			pready_reg    <= 1'b0;
			pslverr_reg   <= 1'b0;
			lower_pin_reg <= 8'h00;
			upper_pin_reg <= 2'h0;
			car_pin_reg   <= 1'b0;
			wdt_rst_reg   <= 1'b0;
			stop_pin_reg  <= 1'b0;
			osc_pin_reg   <= 1'b1;
		end else if (ce_i) begin
			state_reg     <= state_next;
			cyc_reg       <= cyc_next;
			wait_reg      <= wait_next;
			y_reg         <= y_next;
			x_reg         <= x_next;
			wake_en_reg   <= wake_en_next;
			mode_reg      <= mode_next;
			car_on_reg    <= car_on_next;
			lower_reg     <= lower_next;
			upper_reg     <= upper_next;
			pend_reg      <= pend_next;
			op_reg        <= op_next;
			prdata_reg    <= prdata_next;
			pready_reg    <= pready_next;
			pslverr_reg   <= pslverr_next;
			lower_pin_reg <= lower_pin_next;
			upper_pin_reg <= upper_pin_next;
			car_pin_reg   <= car_pin_next;
			wdt_rst_reg   <= wdt_rst_next;
			stop_pin_reg  <= stop_pin_next;
			osc_pin_reg   <= osc_pin_next;
		end
	end

	assign prdata_o             = prdata_reg;
	assign pready_o             = pready_reg;
	assign pslverr_o            = pslverr_reg;
	assign lower_output_lines_o = lower_pin_reg;
	assign upper_output_pair_o  = upper_pin_reg;
	assign carrier_output_pin_o = car_pin_reg;
	assign wdt_reset_o          = wdt_rst_reg;
	assign stop_mode_o          = stop_pin_reg;
	assign osc_run_o            = osc_pin_reg;

endmodule // cws_carrier_watchdog

/* core/cws_pkg.sv */
// Purpose: Shared constants for the carrier, watchdog and stop controller
// Assumes: One oscillator clock per mclk_i cycle
// Notes:   Byte addresses of the APB register map

package cws_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CMD  = 8'h00;
	localparam logic [7:0] ADDR_XY   = 8'h04;
	localparam logic [7:0] ADDR_WAKE = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0C;
	localparam logic [7:0] ADDR_OUT  = 8'h10;

	// Field positions
	localparam int Y_LSB      = 0;
	localparam int X_LSB      = 4;
	localparam int STAT_WDT   = 8;
	localparam int OUT_UPPER  = 8;
	localparam int OUT_CAR    = 10;
	localparam int OUT_CARON  = 11;
	localparam int OUT_MODE   = 12;

	// ----------------------------------------
	// Instruction codes
	// ----------------------------------------
	localparam logic [3:0] OP_IDLE = 4'h0;
	localparam logic [3:0] OP_SO   = 4'h1;
	localparam logic [3:0] OP_RO   = 4'h2;
	localparam logic [3:0] OP_WATCHDOG_CLEAR_INSTRUCTION = 4'h3;
	localparam logic [3:0] OP_STOP = 4'h4;
	localparam logic [3:0] OP_LPY  = 4'h5;

	// Y selector values for output instructions
	localparam logic [3:0] Y_CARRIER = 4'h8;
	localparam logic [3:0] Y_ALL     = 4'h9;

	// ----------------------------------------
	// Carrier modes and timing in oscillator clocks
	// ----------------------------------------
	localparam logic [2:0] MODE_RESET  = 3'h0;
	localparam logic [2:0] MODE_STATIC = 3'h5;
	localparam logic [6:0] PER_12 = 7'h0C;
	localparam logic [6:0] PER_8  = 7'h08;
	localparam logic [6:0] PER_11 = 7'h0B;
	localparam logic [6:0] HI_6   = 7'h06;
	localparam logic [6:0] HI_4   = 7'h04;
	localparam logic [6:0] HI_3   = 7'h03;
	localparam logic [6:0] HI_2   = 7'h02;
	localparam int SLOW_SHIFT = 3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int MCLK_PERIOD_NS = 4;
	localparam int CYC_FAST       = 6;
	localparam int CYC_SLOW       = 48;
	localparam int WDT_PRESCALE   = 6;
	localparam int WDT_STAGES     = 14;
	localparam int WDT_OVF_TICKS  = 8192;
	localparam int WAKE_BASE      = 1024;
	localparam int WAKE_MULT      = 8;
	localparam int WAKE_WAIT_CYC  = WAKE_BASE * WAKE_MULT;

	typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAIT} cws_state_type;

endpackage

/* core/cws_carrier_gen.sv */
// Purpose: Carrier pulse counter, high part first in each period
// Assumes: period and high stable while running
// Notes:   Level output is combinational; the top registers it

`timescale 1ns/10ps

module cws_carrier_gen (
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic       ce_i,
	input  wire logic       run_i,
	input  wire logic       restart_i,
	input  wire logic [6:0] period_i,
	input  wire logic [6:0] high_i,
	output logic            level_o
);

	logic [6:0] cnt_reg;
	logic [6:0] cnt_next;

	always_comb begin
		if (!run_i || restart_i || cnt_reg >= period_i - 7'h01) begin
			cnt_next = 7'h00;
		end else begin
			cnt_next = cnt_reg + 7'h01;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 7'h00;
		end else if (ce_i) begin
			cnt_reg <= cnt_next;
		end
	end

	assign level_o = run_i && !restart_i && (cnt_reg < high_i);

endmodule // cws_carrier_gen

/* core/cws_wdt_cnt.sv */
// Purpose: Watchdog prescaler and binary counter
// Assumes: clr_i wins over counting
// Notes:   ovf_o is a one-cycle pulse

`timescale 1ns/10ps

module cws_wdt_cnt #(
	parameter int OVF_TICKS = cws_pkg::WDT_OVF_TICKS
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	input  wire logic        clr_i,
	output logic [13:0]      count_o,
	output logic             ovf_o
);

	localparam logic [2:0]  PRE_LAST = 3'(cws_pkg::WDT_PRESCALE - 1);
	localparam logic [13:0] CNT_LAST = 14'(OVF_TICKS - 1);

	logic [2:0]  pre_reg;
	logic [2:0]  pre_next;
	logic [13:0] cnt_reg;
	logic [13:0] cnt_next;
	logic        tick;

	assign tick = (pre_reg == PRE_LAST);

	always_comb begin
		pre_next = tick ? 3'h0 : pre_reg + 3'h1;
		cnt_next = tick ? cnt_reg + 14'h0001 : cnt_reg;
		if (clr_i || ovf_o) begin
			pre_next = 3'h0;
			cnt_next = 14'h0000;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pre_reg <= 3'h0;
			cnt_reg <= 14'h0000;
		end else if (ce_i) begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
		end
	end

	assign ovf_o   = !clr_i && tick && (cnt_reg == CNT_LAST);
	assign count_o = cnt_reg;

endmodule // cws_wdt_cnt

/* verif/cws_checker_assertions.sv */
// Purpose: Port-level checks of the carrier, watchdog and stop controller
// Assumes: Bound to the top module; pins lag internal state by one clock
// Notes:   Watchdog interval is measured from reset, overflow or stop exit
`timescale 1ns/10ps
module cws_checker #(
	parameter bit OPT_STOP_LOWER0 = 1'b0,
	parameter int WDT_OVF_TICKS   = 8192
) (
	input wire logic       mclk_i,
	input wire logic       rst_b_i,
	input wire logic       psel_i,
	input wire logic       penable_i,
	input wire logic       pready_o,
	input wire logic       pslverr_o,
	input wire logic [3:0] wake_k_i,
	input wire logic [3:0] wake_r_i,
	input wire logic [7:0] lower_output_lines_o,
	input wire logic [1:0] upper_output_pair_o,
	input wire logic       carrier_output_pin_o,
	input wire logic       wdt_reset_o,
	input wire logic       stop_mode_o,
	input wire logic       osc_run_o
);
	localparam int OVF_MIN = 6 * WDT_OVF_TICKS - 6;
	int run_cnt_reg;
	int run_cnt_next;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// ----------------------------------------
	// Clocks since the last reset, watchdog overflow or stop
	// ----------------------------------------
	always_comb begin
		run_cnt_next = (wdt_reset_o || stop_mode_o) ? 0 : run_cnt_reg + 1;
	end
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			run_cnt_reg <= 0;
		else
			run_cnt_reg <= run_cnt_next;
	end
	sequence s_stopped;
		stop_mode_o [*2];
	endsequence
	a_reset_idle: assert property ($rose(rst_b_i) |-> !carrier_output_pin_o && osc_run_o
		&& lower_output_lines_o == 8'h00 && upper_output_pair_o == 2'h0)
		else $error("outputs not idle after reset");
	a_osc_halted: assert property (osc_run_o == !stop_mode_o)
		else $error("oscillator run flag disagrees with stop");
	a_stop_pins_low: assert property (s_stopped |-> upper_output_pair_o == 2'h0
		&& !carrier_output_pin_o) else $error("upper pair or carrier high in stop");
	a_stop_lower_lines: assert property (s_stopped |-> (OPT_STOP_LOWER0 ?
		lower_output_lines_o == 8'h00 : $stable(lower_output_lines_o)))
		else $error("lower lines wrong in stop");
	a_stop_needs_wake: assert property (stop_mode_o && &wake_k_i && &wake_r_i
		|=> stop_mode_o) else $error("stop ended without wake input");
	a_wdt_quiet_stop: assert property (stop_mode_o |-> !wdt_reset_o)
		else $error("watchdog fired in stop");
	a_wdt_one_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
		else $error("watchdog reset longer than one cycle");
	a_wdt_interval: assert property (wdt_reset_o |-> run_cnt_reg >= OVF_MIN)
		else $error("watchdog overflow too early");
	a_wdt_clears_pins: assert property (wdt_reset_o |-> ##[1:2] (!carrier_output_pin_o
		&& lower_output_lines_o == 8'h00 && upper_output_pair_o == 2'h0))
		else $error("outputs not cleared by watchdog reset");
	a_apb_one_wait: assert property (psel_i && penable_i && !$past(penable_i)
		|-> !pready_o ##1 pready_o) else $error("bus answer not after one wait");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
endmodule // cws_checker
bind cws_carrier_watchdog cws_checker #(.OPT_STOP_LOWER0(OPT_STOP_LOWER0),
	.WDT_OVF_TICKS(WDT_OVF_TICKS)) cws_checker_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
	.psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.wake_k_i(wake_k_i), .wake_r_i(wake_r_i), .lower_output_lines_o(lower_output_lines_o),
	.upper_output_pair_o(upper_output_pair_o), .carrier_output_pin_o(carrier_output_pin_o),
	.wdt_reset_o(wdt_reset_o), .stop_mode_o(stop_mode_o), .osc_run_o(osc_run_o));

/* verif/cws_far_side.sv */
// Purpose: Wake inputs and carrier load beside the controller
// Assumes: Idle wake lines sit high through pull-ups
// Notes:   Measures high time and period of the carrier in clocks
`timescale 1ns/10ps
module cws_far_side (
	input  wire logic       mclk_i,
	input  wire logic [7:0] wake_req_i,
	input  wire logic       carrier_i,
	output logic      [3:0] wake_k_o,
	output logic      [3:0] wake_r_o,
	output logic      [7:0] hi_len_o,
	output logic      [7:0] per_len_o
);
	logic       prev;
	logic [7:0] cnt;
	// A requested line is pulled to the low wake level
	assign wake_k_o = ~wake_req_i[3:0];
	assign wake_r_o = ~wake_req_i[7:4];
	always @(posedge mclk_i) begin
		prev <= carrier_i;
		cnt <= (carrier_i && !prev) ? 8'h01 : cnt + 8'h01;
		if (carrier_i && !prev)
			per_len_o <= cnt;
		if (!carrier_i && prev)
			hi_len_o <= cnt;
	end
endmodule // cws_far_side

/* verif/cws_carrier_watchdog_tb.sv */
// Purpose: Self-checking bench for the carrier, watchdog and stop controller
// Assumes: Short watchdog and wake counts set through parameters
// Notes:   Carrier mode table loop, then stop, wake and watchdog cases
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module cws_carrier_watchdog_tb;
	localparam int OVF = 64;
	logic        mclk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, car, wdt, stop, osc;
	logic        err;
	logic [1:0]  upper;
	logic [3:0]  wk, wr_n;
	logic [7:0]  paddr, lower, wake, hi_len, per_len;
	logic [31:0] pwdata, prdata, r;
	int          n_mismatch, total_checks, i, n;
	logic [3:0]  md [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
	logic [7:0]  per [6] = '{8'h0C, 8'h0C, 8'h08, 8'h08, 8'h0B, 8'h0C};
	logic [7:0]  hi [6] = '{8'h06, 8'h04, 8'h04, 8'h02, 8'h04, 8'h03};
	cws_carrier_watchdog #(.OPT_WDT_BY_CAR(1'b1), .WDT_OVF_TICKS(OVF), .WAKE_WAIT_CYC(16))
		cws_carrier_watchdog_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.wake_k_i(wk), .wake_r_i(wr_n), .lower_output_lines_o(lower),
		.upper_output_pair_o(upper), .carrier_output_pin_o(car), .wdt_reset_o(wdt),
		.stop_mode_o(stop), .osc_run_o(osc));
	cws_far_side cws_far_side_inst (.mclk_i(mclk_i), .wake_req_i(wake), .carrier_i(car),
		.wake_k_o(wk), .wake_r_o(wr_n), .hi_len_o(hi_len), .per_len_o(per_len));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk_i);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_i);
		if (k >= 20) begin
			n_mismatch++;
			give_verdict();
		end
	endtask
	task automatic op(input logic [1:0] x, input logic [3:0] y, input logic [3:0] c);
		apb(1'b1, cws_pkg::ADDR_XY, {26'h0, x, y});
		apb(1'b1, cws_pkg::ADDR_CMD, {28'h0, c});
		repeat (8) @(posedge mclk_i);
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	initial begin
		{rst_b_i, psel, penable, pwrite, paddr, pwdata, wake} = '0;
		repeat (16) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		`CHK("reset pins", 11'h000, {lower, upper, car})
		apb(1'b0, cws_pkg::ADDR_OUT, 32'h0);
		`CHK("out after reset", 33'h0, {err, r})
		// ----------------------------------------
		// Carrier mode table
		// ----------------------------------------
		for (i = 0; i < 6; i++) begin
			op(2'h0, md[i], cws_pkg::OP_LPY);
			op(2'h0, cws_pkg::Y_CARRIER, cws_pkg::OP_SO);
			repeat (40) @(posedge mclk_i);
			`CHK("period", per[i], per_len)
			`CHK("high time", hi[i], hi_len)
			apb(1'b0, cws_pkg::ADDR_OUT, 32'h0);
			`CHK("mode", md[i][2:0], r[14:12])
			op(2'h0, cws_pkg::Y_CARRIER, cws_pkg::OP_RO);
			`CHK("carrier off", 1'b0, car)
		end
		op(2'h0, 4'h5, cws_pkg::OP_LPY);
		op(2'h0, cws_pkg::Y_CARRIER, cws_pkg::OP_SO);
		repeat (30) @(posedge mclk_i);
		`CHK("static carrier", 1'b1, car)
		// ----------------------------------------
		// Stop, ignored input, wake and wait
		// ----------------------------------------
		apb(1'b1, cws_pkg::ADDR_WAKE, 32'h1);
		op(2'h0, cws_pkg::Y_ALL, cws_pkg::OP_SO);
		op(2'h0, 4'h0, cws_pkg::OP_STOP);
		`CHK("stop flags", 2'b10, {stop, osc})
		`CHK("stop pins", {8'hFF, 3'h0}, {lower, upper, car})
		apb(1'b0, cws_pkg::ADDR_STAT, 32'h0);
		`CHK("stop status", 16'h0001, {r[21:8], r[1:0]})
		wake <= 8'h10;
		repeat (10) @(posedge mclk_i);
		`CHK("disabled input", 1'b1, stop)
		wake <= 8'h01;
		repeat (3) @(posedge mclk_i);
		`CHK("wake pins", {8'hFF, 3'h1}, {lower, upper, car})
		apb(1'b0, cws_pkg::ADDR_STAT, 32'h0);
		`CHK("waiting", 2'h2, r[1:0])
		repeat (20) @(posedge mclk_i);
		apb(1'b0, cws_pkg::ADDR_STAT, 32'h0);
		`CHK("running", 2'h0, r[1:0])
		op(2'h0, 4'h0, cws_pkg::OP_STOP);
		`CHK("stop as idle", 1'b0, stop)
		wake <= 8'h00;
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 33'h100000000, {err, r})
		// ----------------------------------------
		// Watchdog clear, overflow and carrier clear
		// ----------------------------------------
		op(2'h0, 4'h0, cws_pkg::OP_WATCHDOG_CLEAR_INSTRUCTION);
		apb(1'b0, cws_pkg::ADDR_STAT, 32'h0);
		`CHK("cleared count", 10'h000, r[21:12])
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (wdt !== 1'b1 && n < 500);
		`CHK("overflow time", 1'b1, n > 6 * OVF - 24 && n <= 6 * OVF)
		repeat (3) @(posedge mclk_i);
		`CHK("pins after overflow", 11'h000, {lower, upper, car})
		apb(1'b0, cws_pkg::ADDR_OUT, 32'h0);
		`CHK("out after overflow", 32'h0, r)
		repeat (200) @(posedge mclk_i);
		op(2'h0, cws_pkg::Y_CARRIER, cws_pkg::OP_SO);
		apb(1'b0, cws_pkg::ADDR_STAT, 32'h0);
		`CHK("carrier clears count", 10'h000, r[21:12])
		op(2'h2, 4'h1, cws_pkg::OP_SO);
		op(2'h0, 4'h3, cws_pkg::OP_SO);
		`CHK("single lines", 10'h022, {lower, upper})
		// ----------------------------------------
		// Reset in mid-run
		// ----------------------------------------
		rst_b_i <= 1'b0;
		repeat (28) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		`CHK("pins after reset", 13'h0001, {lower, upper, car, stop, osc})
		apb(1'b0, cws_pkg::ADDR_OUT, 32'h0);
		`CHK("out after second reset", 33'h0, {err, r})
		give_verdict();
	end
endmodule // cws_carrier_watchdog_tb
